// >>> rtl/spi_cmd_port.sv
// Purpose: serial command port with crc, clock count and address checks
// Assumes: sclk_in only toggles while cs_n_in is low (spi mode 0 or 3)
// Notes: frame logic runs on sclk_in; registers live on sys_clk_in
`timescale 1ns/100ps
module spi_cmd_port
    import spi_cmd_pkg::*;
#(
    parameter int SW_W = 4
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic [SW_W-1:0] sw_out,
    output logic [2:0] err_config_out,
    output logic [2:0] err_flags_out
);
    localparam int VIEW_W = SW_W + 6;
    localparam int RES_W = 3 + CNT_W + FRAME_BITS + 1;

    // address legality for a command header (op bit plus address)
    function automatic logic addr_invalid(input logic [7:0] hdr);
        logic [6:0] a;
        logic rd;
        a = hdr[6:0];
        rd = hdr[7];
        addr_invalid = !((a == ADDR_SW_DATA) || (a == ADDR_ERR_CONFIG) ||
            (a == ADDR_ERR_FLAGS && rd) ||
            (a == CLEAR_FRAME[14:8] && !rd));
    endfunction

    // register contents as seen by a read of address a
    function automatic logic [7:0] read_value(input logic [6:0] a,
                                              input logic [VIEW_W-1:0] v);
        read_value = 8'h00;
        if (a == ADDR_SW_DATA) begin
            read_value = 8'(v[SW_W-1:0]);
        end else if (a == ADDR_ERR_CONFIG) begin
            read_value = {5'h00, v[SW_W+5:SW_W+3]};
        end else if (a == ADDR_ERR_FLAGS) begin
            read_value = {5'h00, v[SW_W+2:SW_W]};
        end
    endfunction

    // system domain register file
    logic [SW_W-1:0] sw_data;
    logic [2:0] err_config;
    logic [2:0] err_flags;
    logic link_rst;

    // link domain state
    logic frame_new;
    logic [CNT_W-1:0] cnt_q;
    logic [CRC_FRAME_BITS-1:0] shreg;
    logic [7:0] lat_cmd;
    logic res_addr_bad;
    logic res_commit;
    logic res_crc_bad;
    logic [FRAME_BITS-1:0] res_cmd;
    logic frame_par;
    logic [VIEW_W-1:0] view_m;
    logic [VIEW_W-1:0] view_s;
    logic sdo_oe;

    // open drain: the data level is always low, only the enable moves
    assign sdo_out = 1'b0;
    assign sdo_oe_out = sdo_oe;
    assign sw_out = sw_data;
    assign err_config_out = err_config;
    assign err_flags_out = err_flags;

    // link side decode of the shift path and edge number
    wire crc_en_l = view_s[SW_W+3+CRC_BIT];
    wire [CRC_FRAME_BITS-1:0] next_shift = {shreg[CRC_FRAME_BITS-2:0], sdi_in};
    wire [CNT_W-1:0] cnt_inc = (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
    wire [CNT_W-1:0] edge_num = frame_new ? 5'h01 : cnt_inc;
    wire at_final = !frame_new && (edge_num == (crc_en_l ? CNT_LONG : CNT_SHORT));
    wire [7:0] rx_crc;
    wire crc_match = (rx_crc == next_shift[7:0]);

    spi_crc8 #(
        .DATA_W(FRAME_BITS)
    ) rx_crc_calc (
        .data_in(next_shift[CRC_FRAME_BITS-1:8]),
        .crc_out(rx_crc)
    );

    // frame start marker, preset while chip select is high; the idle
    // level of the serial clock does not matter, so mode 0 and 3 both fit
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            frame_new <= 1'b1;
        end else begin
            frame_new <= 1'b0;
        end
    end

    // one parity flip per clocked frame tells idle frames apart
    always_ff @(posedge sclk_in or posedge link_rst) begin
        if (link_rst) begin
            frame_par <= 1'b0;
        end else if (frame_new) begin
            frame_par <= ~frame_par;
        end
    end

    // sample serial input on the rising edge and count clocks
    always_ff @(posedge sclk_in) begin
        shreg <= next_shift;
        cnt_q <= edge_num;
        view_m <= {err_config, err_flags, sw_data};
        view_s <= view_m;
    end

    // header capture at edge eight: op bit and address
    always_ff @(posedge sclk_in) begin
        if (!frame_new && edge_num == 5'h08) begin
            lat_cmd <= next_shift[7:0];
        end
    end

    // frame results; addr, commit and crc results clear on the first clock of every frame, res_cmd holds
    always_ff @(posedge sclk_in) begin
        if (frame_new) begin
            res_addr_bad <= 1'b0;
            res_commit <= 1'b0;
            res_crc_bad <= 1'b0;
        end else begin
            if (edge_num == 5'h09) begin
                res_addr_bad <= addr_invalid(lat_cmd);
            end
            if (at_final) begin
                // extra clocks past this edge leave the commit in place
                res_commit <= !crc_en_l || crc_match;
                res_crc_bad <= crc_en_l && !crc_match;
                res_cmd <= crc_en_l ? next_shift[CRC_FRAME_BITS-1:8] :
                    next_shift[FRAME_BITS-1:0];
            end
        end
    end

    // readback path: register byte and its crc for the reply
    wire is_read_l = lat_cmd[7];
    wire [7:0] rd_byte = read_value(lat_cmd[6:0], view_s);
    wire [7:0] tx_crc;

    spi_crc8 #(
        .DATA_W(FRAME_BITS)
    ) tx_crc_calc (
        .data_in({ALIGN_PATTERN, rd_byte}),
        .crc_out(tx_crc)
    );

    // output byte and bit index for falling edge n = cnt_q
    wire [CNT_W-1:0] tx_n = frame_new ? 5'h00 : cnt_q;
    wire [CNT_W-1:0] tx_n_m1 = tx_n - 5'h01;
    wire [2:0] bit_idx = ~tx_n_m1[2:0];
    wire in_align = (tx_n != 5'h00) && (tx_n <= 5'h08);
    wire in_data = (tx_n > 5'h08) && (tx_n <= CNT_SHORT) && is_read_l;
    wire in_crc = (tx_n > CNT_SHORT) && (tx_n <= CNT_LONG) && is_read_l &&
        crc_en_l;
    wire [7:0] tx_byte = in_align ? ALIGN_PATTERN :
        in_data ? rd_byte :
        in_crc ? tx_crc : 8'hff;
    wire tx_bit = tx_byte[bit_idx];

    // drive on the falling edge; releasing means a one on the wire
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= ~tx_bit;
        end
    end

    // system side synchronisers for chip select and frame results
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic [RES_W-1:0] res_m;
    logic [RES_W-1:0] res_s;
    logic par_seen;
    wire [RES_W-1:0] res_link = {res_addr_bad, res_commit, res_crc_bad,
        cnt_q, res_cmd, frame_par};

    always_ff @(posedge sys_clk_in) begin
        link_rst <= rst_in;
        res_m <= res_link;
        res_s <= res_m;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            cs_m <= cs_n_in;
            cs_s <= cs_m;
            cs_d <= cs_s;
        end
    end

    // frame end bookkeeping; results are static once chip select is up
    wire s_addr_bad = res_s[RES_W-1];
    wire s_commit = res_s[RES_W-2];
    wire s_crc_bad = res_s[RES_W-3];
    wire [CNT_W-1:0] s_cnt = res_s[RES_W-4:FRAME_BITS+1];
    wire [FRAME_BITS-1:0] s_cmd = res_s[FRAME_BITS:1];
    wire s_par = res_s[0];
    wire frame_done = cs_s && !cs_d;
    wire started = (s_par != par_seen);
    wire [CNT_W-1:0] cnt_eff = started ? s_cnt : 5'h00;
    wire [CNT_W-1:0] cnt_exp = err_config[CRC_BIT] ? CNT_LONG : CNT_SHORT;
    wire commit = frame_done && started && s_commit;
    wire is_clear = commit && (s_cmd == CLEAR_FRAME);
    wire near_clear = s_cmd[15:8] == CLEAR_FRAME[15:8];
    wire s_op_rd = (s_cmd[15] == OP_READ[0]);
    wire writable = (s_cmd[14:8] == ADDR_SW_DATA) ||
        (s_cmd[14:8] == ADDR_ERR_CONFIG);
    wire do_write = commit && !is_clear && !s_op_rd && !s_addr_bad &&
        writable;

    // error events, each gated by its own enable
    wire ev_cnt = frame_done && (cnt_eff != cnt_exp) &&
        err_config[SCLK_BIT];
    wire ev_addr = frame_done && started && err_config[ADDR_BIT] &&
        (s_addr_bad || (commit && near_clear && !is_clear));
    wire ev_crc = frame_done && started && s_crc_bad &&
        err_config[CRC_BIT];
    wire [2:0] ev_vec = {ev_addr, ev_cnt, ev_crc};

    // next values: clear first, then set so a new event is never lost
    wire [2:0] next_flags = (is_clear ? FLAGS_RESET : err_flags) |
        ev_vec;
    wire [SW_W-1:0] next_sw = (do_write && s_cmd[14:8] == ADDR_SW_DATA) ?
        s_cmd[SW_W-1:0] : sw_data;
    wire [2:0] next_cfg = (do_write && s_cmd[14:8] == ADDR_ERR_CONFIG) ?
        s_cmd[2:0] : err_config;

    // register file; reset opens every switch and restores defaults
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sw_data <= SW_RESET;
            err_config <= CFG_RESET;
            err_flags <= FLAGS_RESET;
            par_seen <= 1'b0;
        end else begin
            sw_data <= next_sw;
            err_config <= next_cfg;
            err_flags <= next_flags;
            par_seen <= frame_done ? s_par : par_seen;
        end
    end

    // link side checks, idle while chip select is high
    sequence header_done_s;
        !frame_new && cnt_q == 5'h08;
    endsequence

    property align_bits_p;
        @(posedge sclk_in) disable iff (cs_n_in)
        (!frame_new && cnt_q >= 5'h01 && cnt_q <= 5'h08) |->
            sdo_oe == ~ALIGN_PATTERN[3'(5'h08 - cnt_q)];
    endproperty
    align_bits_a: assert property (align_bits_p)
        else $error("alignment bit wrong on serial output");

    header_latch_a: assert property (
        @(posedge sclk_in) disable iff (cs_n_in)
        header_done_s |-> lat_cmd == shreg[7:0])
        else $error("address not latched at edge eight");

    read_data_a: assert property (
        @(posedge sclk_in) disable iff (cs_n_in)
        (!frame_new && lat_cmd[7] && cnt_q >= 5'h09 && cnt_q <= CNT_SHORT)
            |-> sdo_oe == ~rd_byte[3'(CNT_SHORT - cnt_q)])
        else $error("read data bit wrong on serial output");

    short_nowrite_a: assert property (
        @(posedge sclk_in) disable iff (cs_n_in)
        (!frame_new && res_commit) |->
            cnt_q >= (crc_en_l ? CNT_LONG : CNT_SHORT))
        else $error("write committed before the final edge");

    crc_gate_a: assert property (
        @(posedge sclk_in) disable iff (cs_n_in)
        (!frame_new && crc_en_l && res_commit) |-> !res_crc_bad)
        else $error("write committed with bad crc");

    // system side checks
    sequence frame_end_s;
        frame_done && started;
    endsequence

    sticky_flags_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (err_flags & ~$past(err_flags)) == 3'h0 ||
            $past(frame_done) ||
        $past(err_flags) == err_flags)
        else $error("flag changed outside frame end");

    flag_clear_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (is_clear && ev_vec == 3'h0) |=> err_flags == 3'h0)
        else $error("clear frame left a flag set");

    disabled_class_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(err_flags[CRC_BIT]) |-> $past(err_config[CRC_BIT]))
        else $error("crc flag set while crc checking off");

    count_error_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (frame_done && err_config[SCLK_BIT] && cnt_eff != cnt_exp) |=>
            err_flags[SCLK_BIT])
        else $error("clock count error not flagged");

    bad_addr_nowrite_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (frame_end_s and s_addr_bad) |=>
            $stable(sw_data) && $stable(err_config))
        else $error("register written at invalid address");

    reset_default_a: assert property (
        @(posedge sys_clk_in)
        rst_in |=> sw_data == SW_RESET && err_config == CFG_RESET &&
            err_flags == FLAGS_RESET)
        else $error("reset did not restore defaults");
endmodule

// >>> rtl/spi_cmd_pkg.sv
// Purpose: shared constants for the serial command port of a quad switch
// Assumes: 16-bit command frames, 24-bit frames when the crc byte is on
// Notes: register offsets, reset values and field positions live here
package spi_cmd_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CRC_FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam int SCLK_MAX_HZ = 50_000_000;
    localparam logic [4:0] CNT_SHORT = 5'h10;
    localparam logic [4:0] CNT_LONG = 5'h18;
    localparam logic [7:0] ALIGN_PATTERN = 8'h25;
    localparam logic [15:0] CLEAR_FRAME = 16'h6ca9;
    localparam logic [6:0] ADDR_SW_DATA = 7'h01;
    localparam logic [6:0] ADDR_ERR_CONFIG = 7'h02;
    localparam logic [6:0] ADDR_ERR_FLAGS = 7'h03;
    localparam logic [3:0] SW_RESET = 4'h0;
    localparam logic [2:0] CFG_RESET = 3'h6;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam int CRC_BIT = 0;
    localparam int SCLK_BIT = 1;
    localparam int ADDR_BIT = 2;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'h00;
    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_READ = 2'b01
    } op_type;
endpackage

// >>> rtl/spi_crc8.sv
// Purpose: combinational crc-8 over a parallel word, msb first
// Assumes: polynomial and seed from the shared package
// Notes: pure logic, used both for checking and for readback
`timescale 1ns/100ps
module spi_crc8
    import spi_cmd_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic [DATA_W-1:0] data_in,
    output logic [7:0] crc_out
);
    // bitwise long division, msb of the word first
    always_comb begin
        logic [7:0] acc;
        acc = CRC_SEED;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (acc[7] ^ data_in[i]) begin
                acc = {acc[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                acc = {acc[6:0], 1'b0};
            end
        end
        crc_out = acc;
    end
endmodule

// >>> tb/spi_host_model.sv
// Purpose: host controller model for the serial command port
// Assumes: mode 0, serial clock idles low and runs only inside frames
// Notes: sdo is sampled 40 ns after each falling edge
`timescale 1ns/100ps
module spi_host_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out,
    input wire logic sdo_line_in
);
    localparam int HALF = 80;
    // idle levels before any frame
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // one frame, msb first, n clocks of 240 ns
    task automatic xfer(input logic [23:0] bits, input int n,
            output logic [23:0] rx);
        rx = 24'h000000;
        cs_n_out = 1'b0;
        #(HALF);
        for (int i = 0; i < n; i++) begin
            sdi_out = bits[23 - i];
            #(HALF) sclk_out = 1'b1;
            #(HALF) sclk_out = 1'b0;
            #(HALF / 2) rx = {rx[22:0], sdo_line_in};
            #(HALF / 2);
        end
        cs_n_out = 1'b1;
        // released data line flips so a stale bit is never trusted
        sdi_out = ~sdi_out;
        #(400);
    endtask
endmodule

// >>> tb/spi_cmd_port_error_check_bench.sv
// Purpose: self-checking bench for the serial command port
// Assumes: host model drives frames, sdo wire has a pull-up
// Notes: each check waits for the result to cross into the system clock
`timescale 1ns/100ps
module spi_cmd_port_error_check_bench
    import spi_cmd_pkg::*;
;
    logic sys_clk_in;
    logic rst_in;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo_out;
    logic sdo_oe_out;
    logic sdo_line;
    logic [3:0] sw;
    logic [2:0] cfg;
    logic [2:0] flags;
    logic [23:0] rx;
    int miscompares = 0;
    int checks_done = 0;

    // open drain wire: pulled low by enable, else pull-up
    assign sdo_line = sdo_oe_out ? 1'b0 : 1'b1;

    spi_cmd_port #(.SW_W(4)) u_spi_cmd_port (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .sclk_in(sclk),
        .cs_n_in(cs_n),
        .sdi_in(sdi),
        .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out),
        .sw_out(sw),
        .err_config_out(cfg),
        .err_flags_out(flags)
    );

    spi_host_model u_spi_host_model (
        .sclk_out(sclk),
        .cs_n_out(cs_n),
        .sdi_out(sdi),
        .sdo_line_in(sdo_line)
    );

    // 20 mhz system clock
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // msb-first crc, poly 0x07, seed zero
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp,
            input string msg);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    // one frame; bad flips the crc lsb to force a mismatch
    task automatic cmd(input logic [15:0] p, input int n,
            input logic crc_on, input logic bad);
        logic [7:0] c;
        c = crc8(p) ^ {7'h00, bad};
        @(posedge sys_clk_in);
        #5;
        u_spi_host_model.xfer(crc_on ? {p, c} : {p, 8'h00}, n, rx);
        @(posedge sys_clk_in);
        #5;
    endtask

    task automatic regs(input logic [3:0] s, input logic [2:0] c,
            input logic [2:0] f);
        check(24'(sw), 24'(s), "switch state");
        check(24'(cfg), 24'(c), "error config");
        check(24'(flags), 24'(f), "error flags");
        check(24'(sdo_out), 24'h0, "sdo level not low");
        check(24'(sdo_oe_out), 24'h0, "sdo driven while idle");
    endtask

    task automatic do_reset();
        @(posedge sys_clk_in);
        #5 rst_in = 1'b1;
        // two cycles are enough: the chip select synchroniser resets idle
        repeat (2) @(posedge sys_clk_in);
        #5 rst_in = 1'b0;
        repeat (4) @(posedge sys_clk_in);
        #5;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        miscompares++;
        conclude();
    end

    // main sequence
    initial begin
        rst_in = 1'b1;
        do_reset();
        regs(4'h0, 3'h6, 3'h0);
        cmd({1'b0, ADDR_SW_DATA, 8'h05}, 16, 1'b0, 1'b0);
        check(24'(rx[15:8]), 24'(ALIGN_PATTERN), "align");
        check(24'(rx[7:0]), 24'hff, "write sdo released");
        regs(4'h5, 3'h6, 3'h0);
        cmd({1'b1, ADDR_SW_DATA, 8'h0a}, 16, 1'b0, 1'b0);
        check(24'(rx[7:0]), 24'h05, "read switch");
        regs(4'h5, 3'h6, 3'h0);
        // short frame never writes, long frame writes and flags
        cmd({1'b0, ADDR_SW_DATA, 8'h0a}, 12, 1'b0, 1'b0);
        regs(4'h5, 3'h6, 3'h2);
        cmd({1'b0, ADDR_SW_DATA, 8'h0a}, 20, 1'b0, 1'b0);
        regs(4'ha, 3'h6, 3'h2);
        cmd(CLEAR_FRAME, 16, 1'b0, 1'b0);
        regs(4'ha, 3'h6, 3'h0);
        cmd({1'b0, 7'h05, 8'h01}, 16, 1'b0, 1'b0);
        regs(4'ha, 3'h6, 3'h4);
        cmd(CLEAR_FRAME, 16, 1'b0, 1'b0);
        cmd({1'b0, ADDR_ERR_FLAGS, 8'h07}, 16, 1'b0, 1'b0);
        regs(4'ha, 3'h6, 3'h4);
        cmd({1'b0, ADDR_ERR_CONFIG, 8'h02}, 16, 1'b0, 1'b0);
        regs(4'ha, 3'h2, 3'h4);
        cmd(CLEAR_FRAME, 16, 1'b0, 1'b0);
        cmd({1'b1, 7'h0b, 8'h00}, 16, 1'b0, 1'b0);
        regs(4'ha, 3'h2, 3'h0);
        // all three checks on, frames grow to 24 clocks
        cmd({1'b0, ADDR_ERR_CONFIG, 8'h07}, 16, 1'b0, 1'b0);
        cmd({1'b0, ADDR_SW_DATA, 8'h03}, 24, 1'b1, 1'b0);
        regs(4'h3, 3'h7, 3'h0);
        cmd({1'b0, ADDR_SW_DATA, 8'h0c}, 24, 1'b1, 1'b1);
        regs(4'h3, 3'h7, 3'h1);
        cmd({1'b1, ADDR_ERR_FLAGS, 8'h00}, 24, 1'b1, 1'b0);
        check(rx, {ALIGN_PATTERN, 8'h01, crc8(16'h2501)}, "crc read");
        cmd({1'b1, ADDR_ERR_CONFIG, 8'h00}, 24, 1'b1, 1'b0);
        check(rx, {ALIGN_PATTERN, 8'h07, crc8(16'h2507)}, "cfg read");
        cmd(CLEAR_FRAME, 24, 1'b1, 1'b0);
        regs(4'h3, 3'h7, 3'h0);
        cmd({1'b0, ADDR_SW_DATA, 8'h0c}, 16, 1'b1, 1'b0);
        regs(4'h3, 3'h7, 3'h2);
        do_reset();
        regs(4'h0, 3'h6, 3'h0);
        conclude();
    end
endmodule
